// ===== design/rsm_defines.svh
// constants for the 12.8 kHz frame resampler
`ifndef RSM_DEFINES_SVH
`define RSM_DEFINES_SVH
// rate select codes
`define RSM_RATE_8K 2'h0
`define RSM_RATE_16K 2'h1
`define RSM_RATE_32K 2'h2
`define RSM_RATE_48K 2'h3
// input samples per 20 ms frame
`define RSM_LEN_8K 10'h0a0
`define RSM_LEN_16K 10'h140
`define RSM_LEN_32K 10'h280
`define RSM_LEN_48K 10'h3c0
// upsampling factors and half filter spans in input samples
`define RSM_UP_8K 4'h8
`define RSM_UP_16K 4'hc
`define RSM_UP_32K 4'h6
`define RSM_UP_48K 4'h4
`define RSM_HALF_16K 6'h0f
`define RSM_HALF_32K 6'h1e
`define RSM_HALF_48K 6'h2d
`define RSM_HALF_8K 6'h0f
// decimation numerators, 8 kHz delay offset, filter centre taps
`define RSM_DEC_FUP 4'hf
`define RSM_DEC_8K 4'h5
`define RSM_OFF_8K 6'h08
`define RSM_CTR_FUP 9'h0b4
`define RSM_CTR_8K 9'h078
// output gain up/15 and 8/5 in q14
`define RSM_GAIN_16K 16'h3333
`define RSM_GAIN_32K 16'h199a
`define RSM_GAIN_48K 16'h1111
`define RSM_GAIN_8K 16'h6666
`define RSM_GAIN_SHIFT 29
`define RSM_Q15 15
`define RSM_Q12 12
// upsampled frame span and last 64 kHz index
`define RSM_SPAN_192K 14'h0f00
`define RSM_LAST_64K 11'h537
// output samples per frame, last output index
`define RSM_OUT_LAST 10'h0ff
// prediction analysis
`define RSM_SEG_START 12'h028
`define RSM_SEG_LAST 7'h77
`define RSM_ORDER 5'h10
`define RSM_PRED_LAST 7'h06
// coefficient table selects
`define RSM_SEL_LP64 3'h0
`define RSM_SEL_LP40 3'h1
`define RSM_SEL_LP39 3'h2
`define RSM_SEL_WIN 3'h3
`define RSM_SEL_LAG_WINDOW 3'h4
`endif

// ===== design/rsm_pkg.sv
// types shared by the resampler blocks
package rsm_pkg;
   typedef enum logic [9:0] {
      RSM_IDLE = 10'h001,
      RSM_LOAD = 10'h002,
      RSM_WIN = 10'h004,
      RSM_MU = 10'h008,
      RSM_PRE = 10'h010,
      RSM_ACOR = 10'h020,
      RSM_LAGW = 10'h040,
      RSM_LEVD = 10'h080,
      RSM_PRED = 10'h100,
      RSM_FILT = 10'h200
   } rsm_state_t;
   typedef struct packed {
      logic [9:0] flen;
      logic [3:0] up;
      logic [3:0] num;
      logic [5:0] half;
      logic [5:0] doff;
      logic [8:0] ctr;
      logic [15:0] gain;
      logic [2:0] sel;
   } rsm_rcfg_t;
endpackage : rsm_pkg

// ===== design/rsm_fifo.sv
// output sample fifo with valid/ready on both sides
`timescale 1ns/10ps
module rsm_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } rsm_fifo_st_t;
   rsm_fifo_st_t s_r;
   rsm_fifo_st_t s_nxt;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : step

   assign in_ready_o = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (s_r.cnt != '0);
   assign out_data_o = s_r.mem[s_r.rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data_i;
         s_nxt.wp = step(s_r.wp);
      end
      if (pop) begin
         s_nxt.rp = step(s_r.rp);
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : rsm_fifo

// ===== design/rsm_core.sv
// frame resampler from 8/16/32/48 kHz to 12.8 kHz
`timescale 1ns/10ps
`include "rsm_defines.svh"
// Behaviour
// R01: input rate is 8, 16, 32 or 48 kHz
// R02: wideband path: upsample, 6.4 kHz lowpass, decimate
// R03: upsample factor 12, 6 or 4
// R04: upsampled frame spans 3840 samples
// R05: 361-tap filter centred, taps -180 to 180
// R06: keep one in 15, gain factor/15, 256 outputs
// R07: wideband delay is 15 samples at 16 kHz
// R08: narrowband force selects 4 kHz cutoff
// R09: 8 kHz path: 241-tap 3.9 kHz filter
// R10: 8 kHz delay 8 samples via prediction
// R11: order-16 prediction from samples 40 to 159
// R12: asymmetric 120-point analysis window
// R13: emphasis coefficient is lag1 over lag0
// R14: emphasise, window, autocorrelate lags 0 to 16
// R15: lag-window each autocorrelation lag
// R16: levinson-durbin, then zero-input predict 7 samples
// R17: de-emphasise predictions, append at 160 to 166
// R18: 8 kHz: upsample 8, decimate 5, gain 8/5
// R19: polyphase, 30 taps, offset 8, phase n mod 8
// R20: frame in with rate select, done after 256
// R21: keep cross-frame history, cleared on reset
module rsm_core #(
   parameter int ABW = 11,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [1:0] rate_i,
   input wire logic nb_force_i,
   input wire logic [15:0] hp_filtered_input_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic [15:0] coef_i,
   output logic [2:0] coef_sel_o,
   output logic [8:0] coef_addr_o,
   output logic [15:0] out_sample_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic frame_done_o
);
   localparam int BUF_LEN = 1 << ABW;
   typedef struct packed {
      rsm_pkg::rsm_state_t st;
      logic [BUF_LEN-1:0][15:0] mem;
      logic [ABW-1:0] wp;
      logic [ABW-1:0] base;
      logic [9:0] cnt;
      logic [6:0] idx;
      logic [4:0] k;
      logic ph;
      logic [1:0] rate;
      logic nb;
      logic [47:0] acc;
      logic [47:0] r1;
      logic [16:0][47:0] r;
      logic [16:0][23:0] a;
      logic [119:0][15:0] pw;
      logic [15:0][15:0] pe;
      logic [15:0] emph_coef;
      logic [47:0] err;
      logic [15:0] prv;
      logic [2:0] csel;
      logic [8:0] caddr;
      logic rdy;
      logic push;
      logic [15:0] pdat;
      logic [7:0] npush;
      logic [15:0] od;
      logic ov;
      logic done;
   } rsm_core_st_t;
   rsm_core_st_t s_r;
   rsm_core_st_t s_nxt;
   rsm_pkg::rsm_rcfg_t rc;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [15:0] fifo_out_data;
   logic fifo_take;

   function automatic rsm_pkg::rsm_rcfg_t rcfg(input logic [1:0] rate);
      rsm_pkg::rsm_rcfg_t c;
      c = '{`RSM_LEN_16K, `RSM_UP_16K, `RSM_DEC_FUP, `RSM_HALF_16K,
            `RSM_HALF_16K, `RSM_CTR_FUP, `RSM_GAIN_16K, `RSM_SEL_LP64};
      unique case (rate)
         `RSM_RATE_8K: begin
            c = '{`RSM_LEN_8K, `RSM_UP_8K, `RSM_DEC_8K, `RSM_HALF_8K,
                  `RSM_OFF_8K, `RSM_CTR_8K, `RSM_GAIN_8K, `RSM_SEL_LP39};
         end
         `RSM_RATE_16K: begin
         end
         `RSM_RATE_32K: begin
            c = '{`RSM_LEN_32K, `RSM_UP_32K, `RSM_DEC_FUP, `RSM_HALF_32K,
                  `RSM_HALF_32K, `RSM_CTR_FUP, `RSM_GAIN_32K, `RSM_SEL_LP64};
         end
         `RSM_RATE_48K: begin
            c = '{`RSM_LEN_48K, `RSM_UP_48K, `RSM_DEC_FUP, `RSM_HALF_48K,
                  `RSM_HALF_48K, `RSM_CTR_FUP, `RSM_GAIN_48K, `RSM_SEL_LP64};
         end
      endcase
      return c;
   endfunction : rcfg

   function automatic logic signed [95:0] mul(input logic signed [47:0] x,
                                               input logic signed [47:0] y);
      return x * y;
   endfunction : mul

   function automatic logic [15:0] sat16(input logic signed [95:0] v);
      if (v > 96'sh7fff) begin
         return 16'h7fff;
      end else if (v < -96'sh8000) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction : sat16

   function automatic logic [ABW-1:0] baddr(input logic [ABW-1:0] b,
                                             input logic signed [11:0] o);
      return b + ABW'(o);
   endfunction : baddr

   assign rc = rcfg(s_r.rate);
   assign fifo_take = !s_r.ov || out_ready_i;

   always_comb begin
      logic signed [47:0] x;
      logic signed [47:0] w;
      logic signed [47:0] p;
      logic signed [47:0] cf;
      logic signed [95:0] sum;
      logic signed [95:0] kq;
      logic signed [95:0] kk;
      logic signed [11:0] tap;
      logic signed [11:0] soff;
      logic [15:0] ph_n;
      x = '0;
      w = '0;
      p = '0;
      cf = 48'(signed'(coef_i));
      sum = '0;
      kq = '0;
      kk = '0;
      tap = '0;
      soff = '0;
      ph_n = 16'({6'h0, s_r.cnt} % {12'h0, rc.up});
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (s_r.push && fifo_in_ready) begin
         s_nxt.push = 1'b0;
         s_nxt.npush = s_r.npush + 8'h01;
         s_nxt.done = (s_r.npush == 8'hff); // R20
      end
      if (fifo_out_valid && fifo_take) begin
         s_nxt.od = fifo_out_data;
         s_nxt.ov = 1'b1;
      end else if (out_ready_i) begin
         s_nxt.ov = 1'b0;
      end
      unique case (s_r.st)
         rsm_pkg::RSM_IDLE: begin
            if (sample_valid_i) begin
               s_nxt.rate = rate_i; // R01
               s_nxt.nb = nb_force_i;
               s_nxt.base = s_r.wp;
               s_nxt.mem[s_r.wp] = hp_filtered_input_i;
               s_nxt.wp = s_r.wp + 1'b1;
               s_nxt.cnt = 10'h001;
               s_nxt.st = rsm_pkg::RSM_LOAD;
            end
         end
         rsm_pkg::RSM_LOAD: begin
            if (sample_valid_i) begin
               // older samples stay in the ring as filter history
               s_nxt.mem[s_r.wp] = hp_filtered_input_i; // R21
               s_nxt.wp = s_r.wp + 1'b1;
               s_nxt.cnt = s_r.cnt + 10'h001;
               s_nxt.idx = '0;
               s_nxt.ph = 1'b0;
               s_nxt.acc = '0;
               if (s_r.cnt == rc.flen - 10'h001) begin
                  s_nxt.cnt = '0;
                  if (s_r.rate == `RSM_RATE_8K) begin
                     s_nxt.st = rsm_pkg::RSM_WIN; // R10
                     s_nxt.r1 = '0;
                     s_nxt.a = '0;
                     s_nxt.prv = '0;
                  end else begin
                     s_nxt.st = rsm_pkg::RSM_FILT; // R02
                  end
               end
            end
         end
         rsm_pkg::RSM_WIN: begin
            s_nxt.csel = `RSM_SEL_WIN;
            s_nxt.caddr = 9'(s_r.idx); // R12
            s_nxt.ph = !s_r.ph;
            if (s_r.ph) begin
               x = 48'(signed'(s_r.mem[baddr(s_r.base,
                      `RSM_SEG_START + 12'(s_r.idx))])); // R11
               w = 48'(signed'(sat16(mul(x, cf) >>> `RSM_Q15)));
               s_nxt.acc = 48'(signed'(s_r.acc) + mul(w, w));
               s_nxt.r1 = 48'(signed'(s_r.r1) + mul(w, signed'({{32{s_r.prv[15]}},
                           s_r.prv})));
               s_nxt.prv = w[15:0];
               s_nxt.idx = s_r.idx + 7'h01;
               if (s_r.idx == `RSM_SEG_LAST) begin
                  s_nxt.st = rsm_pkg::RSM_MU;
               end
            end
         end
         rsm_pkg::RSM_MU: begin
            s_nxt.emph_coef = '0;
            if (s_r.acc != '0) begin
               s_nxt.emph_coef = sat16((96'(signed'(s_r.r1)) <<< `RSM_Q15) /
                                       96'(signed'(s_r.acc))); // R13
            end
            s_nxt.prv = s_r.mem[baddr(s_r.base, `RSM_SEG_START - 12'h001)];
            s_nxt.idx = '0;
            s_nxt.ph = 1'b0;
            s_nxt.st = rsm_pkg::RSM_PRE;
         end
         rsm_pkg::RSM_PRE: begin
            s_nxt.csel = `RSM_SEL_WIN;
            s_nxt.caddr = 9'(s_r.idx);
            s_nxt.ph = !s_r.ph;
            if (s_r.ph) begin
               x = 48'(signed'(s_r.mem[baddr(s_r.base,
                      `RSM_SEG_START + 12'(s_r.idx))]));
               p = 48'(signed'(sat16(96'(x) - (mul(48'(signed'(s_r.emph_coef)),
                   48'(signed'(s_r.prv))) >>> `RSM_Q15)))); // R14
               s_nxt.pw[s_r.idx] = sat16(mul(p, cf) >>> `RSM_Q15);
               s_nxt.pe = {s_r.pe[14:0], p[15:0]};
               s_nxt.prv = x[15:0];
               s_nxt.idx = s_r.idx + 7'h01;
               if (s_r.idx == `RSM_SEG_LAST) begin
                  s_nxt.st = rsm_pkg::RSM_ACOR;
                  s_nxt.k = '0;
                  s_nxt.idx = '0;
                  s_nxt.acc = '0;
               end
            end
         end
         rsm_pkg::RSM_ACOR: begin
            sum = signed'(s_r.acc) + mul(48'(signed'(s_r.pw[s_r.idx])),
                  48'(signed'(s_r.pw[s_r.idx - {2'h0, s_r.k}])));
            s_nxt.acc = sum[47:0];
            s_nxt.idx = s_r.idx + 7'h01;
            if (s_r.idx == `RSM_SEG_LAST) begin
               s_nxt.r[s_r.k] = sum[47:0]; // R14
               s_nxt.acc = '0;
               s_nxt.k = s_r.k + 5'h01;
               s_nxt.idx = {2'h0, s_r.k} + 7'h01;
               if (s_r.k == `RSM_ORDER) begin
                  s_nxt.idx = '0;
                  s_nxt.ph = 1'b0;
                  s_nxt.st = rsm_pkg::RSM_LAGW;
               end
            end
         end
         rsm_pkg::RSM_LAGW: begin
            s_nxt.csel = `RSM_SEL_LAG_WINDOW;
            s_nxt.caddr = 9'(s_r.idx);
            s_nxt.ph = !s_r.ph;
            if (s_r.ph) begin
               sum = mul(signed'(s_r.r[s_r.idx]), cf) >>> `RSM_Q15; // R15
               s_nxt.r[s_r.idx] = sum[47:0];
               s_nxt.idx = s_r.idx + 7'h01;
               if (s_r.idx == '0) begin
                  s_nxt.err = sum[47:0];
               end
               if (s_r.idx == 7'(`RSM_ORDER)) begin
                  s_nxt.k = 5'h01;
                  s_nxt.st = rsm_pkg::RSM_LEVD;
               end
            end
         end
         rsm_pkg::RSM_LEVD: begin
            // one recursion order per cycle, a in q12, k in q15
            sum = 96'(signed'(s_r.r[s_r.k])) <<< `RSM_Q12;
            for (int j = 1; j < 16; j++) begin
               if (5'(j) < s_r.k) begin
                  sum = sum + mul(48'(signed'(s_r.a[j])),
                        signed'(s_r.r[s_r.k - 5'(j)]));
               end
            end
            if (signed'(s_r.err) > 48'sh0) begin
               kq = -(sum <<< 3) / 96'(signed'(s_r.err)); // R16
            end
            for (int j = 1; j < 16; j++) begin
               if (5'(j) < s_r.k) begin
                  s_nxt.a[j] = 24'(signed'(s_r.a[j]) + (mul(kq[47:0],
                       48'(signed'(s_r.a[s_r.k - 5'(j)]))) >>> `RSM_Q15));
               end
            end
            s_nxt.a[s_r.k] = 24'(kq >>> 3);
            kk = mul(kq[47:0], kq[47:0]);
            s_nxt.err = 48'(signed'(s_r.err) - (mul(kk[47:0],
                        signed'(s_r.err)) >>> 30));
            s_nxt.k = s_r.k + 5'h01;
            if (s_r.k == `RSM_ORDER) begin
               s_nxt.idx = '0;
               s_nxt.prv = s_r.mem[baddr(s_r.base, 12'(`RSM_LEN_8K) - 12'h001)];
               s_nxt.st = rsm_pkg::RSM_PRED;
            end
         end
         rsm_pkg::RSM_PRED: begin
            for (int j = 1; j <= 16; j++) begin
               sum = sum + mul(48'(signed'(s_r.a[j])),
                     48'(signed'(s_r.pe[j-1])));
            end
            p = 48'(signed'(sat16(-(sum >>> `RSM_Q12)))); // R16
            w = 48'(signed'(sat16(96'(p) + (mul(48'(signed'(s_r.emph_coef)),
                48'(signed'(s_r.prv))) >>> `RSM_Q15)))); // R17
            // extended_support_vector tail sits past the frame in the ring
            s_nxt.mem[baddr(s_r.base, 12'(`RSM_LEN_8K) + 12'(s_r.idx))] =
               w[15:0]; // R17
            s_nxt.pe = {s_r.pe[14:0], p[15:0]};
            s_nxt.prv = w[15:0];
            s_nxt.idx = s_r.idx + 7'h01;
            if (s_r.idx == `RSM_PRED_LAST) begin
               s_nxt.idx = '0;
               s_nxt.ph = 1'b0;
               s_nxt.cnt = '0;
               s_nxt.acc = '0;
               s_nxt.st = rsm_pkg::RSM_FILT;
            end
         end
         rsm_pkg::RSM_FILT: begin
            // phase-selected taps only; zeros never multiplied
            tap = 12'(s_r.idx) - 12'(rc.half) + 12'sh001; // R19
            soff = 12'(16'({6'h0, s_r.cnt} * {12'h0, rc.num}) /
                   {12'h0, rc.up}) + tap - 12'(rc.doff); // R07 R10
            s_nxt.csel = (s_r.nb && s_r.rate != `RSM_RATE_8K) ?
                         `RSM_SEL_LP40 : rc.sel; // R08 R09
            s_nxt.caddr = 9'(12'(rc.up) * tap - 12'(ph_n) +
                          12'(rc.ctr)); // R03 R05
            if (!s_r.ph) begin
               if (s_r.idx != '0 || (!s_r.push && fifo_in_ready)) begin
                  s_nxt.ph = 1'b1;
               end
            end else begin
               x = 48'(signed'(s_r.mem[baddr(s_r.base, soff)]));
               sum = signed'(s_r.acc) + mul(x, cf);
               s_nxt.acc = sum[47:0];
               s_nxt.ph = 1'b0;
               s_nxt.idx = s_r.idx + 7'h01;
               if (s_r.idx == {rc.half, 1'b0} - 7'h01) begin
                  s_nxt.pdat = sat16(mul(sum[47:0],
                     48'(rc.gain)) >>> `RSM_GAIN_SHIFT); // R06 R18
                  s_nxt.push = 1'b1;
                  s_nxt.acc = '0;
                  s_nxt.idx = '0;
                  s_nxt.cnt = s_r.cnt + 10'h001;
                  if (s_r.cnt == `RSM_OUT_LAST) begin
                     s_nxt.st = rsm_pkg::RSM_IDLE; // R06
                  end
               end
            end
         end
      endcase
      s_nxt.rdy = (s_nxt.st == rsm_pkg::RSM_IDLE) ||
                  (s_nxt.st == rsm_pkg::RSM_LOAD); // R20
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         s_r <= '0; // R21
         s_r.st <= rsm_pkg::RSM_IDLE;
         s_r.rdy <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   rsm_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(s_r.push),
      .in_data_i(s_r.pdat),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_data_o(fifo_out_data),
      .out_ready_i(fifo_take)
   );

   assign sample_ready_o = s_r.rdy;
   assign coef_sel_o = s_r.csel;
   assign coef_addr_o = s_r.caddr;
   assign out_sample_o = s_r.od;
   assign out_valid_o = s_r.ov;
   assign frame_done_o = s_r.done;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence seq_pred7;
      (s_r.st == rsm_pkg::RSM_PRED) [*7] ##1 (s_r.st == rsm_pkg::RSM_FILT);
   endsequence
   sequence seq_levd16;
      (s_r.st == rsm_pkg::RSM_LEVD) ##15 (s_r.st == rsm_pkg::RSM_LEVD)
         ##1 (s_r.st == rsm_pkg::RSM_PRED);
   endsequence

   chk_ready_state: assert property ( // R20
      sample_ready_o == (s_r.st == rsm_pkg::RSM_IDLE ||
                         s_r.st == rsm_pkg::RSM_LOAD))
      else $error("ready does not follow load state");
   chk_done_count: assert property ( // R06
      frame_done_o |-> s_r.npush == 8'h00 && $past(s_r.push))
      else $error("done without 256th accepted sample");
   chk_nb_cutoff: assert property ( // R08
      (s_r.st == rsm_pkg::RSM_FILT && s_r.ph && s_r.nb &&
       s_r.rate != `RSM_RATE_8K) |-> coef_sel_o == `RSM_SEL_LP40)
      else $error("narrowband force did not pick 4 kHz filter");
   chk_fup_coef: assert property ( // R05
      (s_r.st == rsm_pkg::RSM_FILT && s_r.ph && s_r.rate != `RSM_RATE_8K)
      |-> coef_addr_o >= 9'h001 && coef_addr_o <= 9'h168)
      else $error("wideband tap outside 361-tap span");
   chk_8k_coef: assert property ( // R19
      (s_r.st == rsm_pkg::RSM_FILT && s_r.ph && s_r.rate == `RSM_RATE_8K)
      |-> coef_sel_o == `RSM_SEL_LP39 && coef_addr_o >= 9'h001 &&
          coef_addr_o <= 9'h0f0)
      else $error("8 kHz tap outside 241-tap span");
   chk_up_span: assert property ( // R04
      (s_r.st == rsm_pkg::RSM_FILT && s_r.rate != `RSM_RATE_8K)
      |-> 14'(rc.flen * rc.up) == `RSM_SPAN_192K)
      else $error("upsampled frame is not 3840 samples");
   chk_span_8k: assert property ( // R18
      (s_r.st == rsm_pkg::RSM_FILT && s_r.rate == `RSM_RATE_8K)
      |-> 11'((rc.flen + 10'h007) * rc.up) - 11'h001 == `RSM_LAST_64K)
      else $error("8 kHz upsampled span is wrong");
   chk_pred_len: assert property ( // R17
      $rose(s_r.st == rsm_pkg::RSM_PRED) |-> seq_pred7)
      else $error("prediction did not produce 7 samples");
   chk_levd_len: assert property ( // R16
      $rose(s_r.st == rsm_pkg::RSM_LEVD) |-> seq_levd16)
      else $error("recursion did not run 16 orders");
   chk_win_len: assert property ( // R11
      $rose(s_r.st == rsm_pkg::RSM_WIN) |-> ##240 s_r.st == rsm_pkg::RSM_MU)
      else $error("analysis window pass not 120 points");
   chk_hist_clear: assert property ( // R21
      $rose(rst_b_i) |-> s_r.mem == '0 && s_r.st == rsm_pkg::RSM_IDLE)
      else $error("history not cleared by reset");
endmodule : rsm_core

// ===== tb/rsm_far_model.sv
// coefficient table and downstream sink beside the resampler
`timescale 1ns/10ps
module rsm_far_model (
   input wire logic ref_clk_i,
   input wire logic clr_i,
   input wire logic stall_i,
   input wire logic [2:0] coef_sel_i,
   input wire logic [8:0] coef_addr_i,
   output logic [15:0] coef_o,
   output logic out_ready_o,
   output logic [4:0] sel_seen_o,
   output logic addr_bad_o
);
   logic [8:0] lim;
   // flat taps so a dc input gives a closed-form output
   always_comb begin
      case (coef_sel_i)
         3'h0: begin coef_o = 16'h0100; lim = 9'h168; end
         3'h1: begin coef_o = 16'h0200; lim = 9'h168; end
         3'h2: begin coef_o = 16'h0100; lim = 9'h0f0; end
         3'h3: begin coef_o = 16'h7fff; lim = 9'h077; end
         default: begin coef_o = 16'h7fff; lim = 9'h010; end
      endcase
   end
   always @(negedge ref_clk_i) begin
      out_ready_o <= !stall_i && ($urandom_range(0, 3) != 0);
   end
   always @(posedge ref_clk_i) begin
      if (clr_i) begin
         sel_seen_o <= 5'h00;
         addr_bad_o <= 1'b0;
      end else begin
         if (coef_sel_i <= 3'h4) sel_seen_o[coef_sel_i] <= 1'b1;
         if (coef_sel_i > 3'h4 || coef_addr_i > lim) addr_bad_o <= 1'b1;
      end
   end
endmodule : rsm_far_model

// ===== tb/tb.sv
// self-checking bench for the 12.8 kHz frame resampler
`timescale 1ns/10ps
`include "rsm_defines.svh"
module tb;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [1:0] rate_i = 2'h0;
   logic nb_force_i = 1'b0;
   logic [15:0] din = 16'h0000;
   logic sample_valid_i = 1'b0;
   logic stall = 1'b1;
   logic clr = 1'b1;
   logic sample_ready_o, out_valid_o, out_ready_i, frame_done_o, addr_bad;
   logic [15:0] coef_i, out_sample_o;
   logic [2:0] coef_sel_o;
   logic [8:0] coef_addr_o;
   logic [4:0] sel_seen;
   logic [1:0] rates [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic nbs [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
   logic [15:0] got [$];
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   int dones = 0;
   int t;
   always #5 ref_clk_i = ~ref_clk_i;
   rsm_core u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .rate_i(rate_i), .nb_force_i(nb_force_i),
      .hp_filtered_input_i(din), .sample_valid_i(sample_valid_i),
      .sample_ready_o(sample_ready_o), .coef_i(coef_i),
      .coef_sel_o(coef_sel_o), .coef_addr_o(coef_addr_o),
      .out_sample_o(out_sample_o), .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i), .frame_done_o(frame_done_o));
   rsm_far_model u_far (.ref_clk_i(ref_clk_i), .clr_i(clr),
      .stall_i(stall), .coef_sel_i(coef_sel_o), .coef_addr_i(coef_addr_o),
      .coef_o(coef_i), .out_ready_o(out_ready_i), .sel_seen_o(sel_seen),
      .addr_bad_o(addr_bad));
   task give_verdict();
      if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   // dc input: output n sums the taps whose input index is already filled
   function automatic logic [15:0] exp_out(input logic [1:0] r,
      input logic nb, input logic signed [15:0] x, input int n);
      int f;
      int cnt;
      longint g;
      longint acc;
      f = (r == `RSM_RATE_16K) ? 12 : (r == `RSM_RATE_32K) ? 6 : 4;
      g = (r == `RSM_RATE_16K) ? `RSM_GAIN_16K :
         (r == `RSM_RATE_32K) ? `RSM_GAIN_32K : `RSM_GAIN_48K;
      cnt = (15 * n) / f + 1;
      if (cnt > 360 / f) cnt = 360 / f;
      // 8 kHz: 30 phase taps reaching from 22 samples behind to 7 past the output instant
      if (r == `RSM_RATE_8K) begin
         g = `RSM_GAIN_8K;
         cnt = (5 * n) / 8 + 8;
         if (cnt > 30) cnt = 30;
      end
      acc = longint'(cnt) * x * (nb ? 512 : 256);
      return 16'((acc * g) >>> `RSM_GAIN_SHIFT);
   endfunction : exp_out
   task automatic run_frame(input logic [1:0] r, input logic nb);
      logic signed [15:0] x;
      logic [4:0] m;
      int flen;
      int k;
      int w;
      int taps;
      logic [15:0] o;
      x = 16'($urandom_range(0, 4095)) - 16'h0800;
      taps = (r == `RSM_RATE_32K) ? 60 : (r == `RSM_RATE_48K) ? 90 : 30;
      flen = (r == `RSM_RATE_8K) ? 160 : 320 * int'(r);
      m = (r == `RSM_RATE_8K) ? 5'h1c : nb ? 5'h02 : 5'h01;
      got.delete();
      dones = 0;
      rst_b_i = 1'b0;
      clr = 1'b1;
      stall = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      clr = 1'b0;
      check(16'(sample_ready_o), 16'h0001);
      rate_i = r;
      nb_force_i = nb;
      din = x;
      sample_valid_i = 1'b1;
      // a sample goes in at each rising edge that sees ready high
      for (k = 0; k < flen; k++) begin
         w = 0;
         while (sample_ready_o !== 1'b1 && w < 100) begin
            w++;
            @(negedge ref_clk_i);
         end
         @(negedge ref_clk_i);
      end
      sample_valid_i = 1'b0;
      check(16'(sample_ready_o), 16'h0000);
      // hold the sink off until the buffer fills and the filter stops
      w = 0;
      while (out_valid_o !== 1'b1 && w < 5000) begin
         w++;
         @(negedge ref_clk_i);
      end
      o = out_sample_o;
      repeat (22 * taps) @(negedge ref_clk_i);
      check(16'(out_valid_o), 16'h0001);
      check(out_sample_o, o);
      stall = 1'b0;
      w = 0;
      while (got.size() < 256 && w < 60000) begin
         w++;
         @(negedge ref_clk_i);
      end
      repeat (20) @(negedge ref_clk_i);
      check(16'(got.size()), 16'h0100);
      check(16'(dones), 16'h0001);
      check(16'(sel_seen & m), 16'(m));
      check(16'(addr_bad), 16'h0000);
      for (k = 0; k < got.size(); k++) begin
         if (r != `RSM_RATE_8K || (5 * k) / 8 <= 152) begin
            check(got[k], exp_out(r, nb, x, k));
         end
      end
   endtask : run_frame
   always @(posedge ref_clk_i) begin
      cycles++;
      if (out_valid_o === 1'b1 && out_ready_i) got.push_back(out_sample_o);
      if (frame_done_o === 1'b1) dones++;
      // four frames need about 115k cycles in all
      if (cycles == 130000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'hfcf65e2d));
      repeat (10) @(negedge ref_clk_i);
      for (t = 0; t < 4; t++) run_frame(rates[t], nbs[t]);
      give_verdict();
   end
endmodule : tb
